// ### serial_mode_pkg.sv
// Package for the serial channel mode configuration block.
package serial_mode_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [19:0] CH0_MODE_IDX = 20'hF0110;
  localparam logic [19:0] CH1_MODE_IDX = 20'hF0112;
  localparam logic [19:0] START_IDX = 20'hF0114;
  localparam logic [19:0] IRQ_STAT_IDX = 20'hF0115;
  localparam logic [19:0] IRQ_MASK_IDX = 20'hF0116;
  // Mode register reset value, fixed-one bit and writable masks.
  localparam logic [15:0] MODE_RESET = 16'h0020;
  localparam logic [15:0] MODE_FIXED_ONE = 16'h0020;
  localparam logic [15:0] MODE_CH0_MASK = 16'hC007;
  localparam logic [15:0] MODE_CH1_MASK = 16'hC147;
  // Mode register field positions.
  localparam int CKS_BIT = 15;
  localparam int CCS_BIT = 14;
  localparam int STS_BIT = 8;
  localparam int SIS_BIT = 6;
  localparam int MD_HI_BIT = 2;
  localparam int MD_LO_BIT = 1;
  localparam int MD_IRQ_BIT = 0;
  // Protocol encodings.
  localparam logic [1:0] PROTO_SPI = 2'h0;
  localparam logic [1:0] PROTO_UART = 2'h1;
  localparam logic [1:0] PROTO_I2C = 2'h2;
  localparam logic [1:0] PROTO_BAD = 2'h3;
  // Start register layout: start bits low, stop bits from bit 8.
  localparam int STOP_BASE = 8;
  // Interrupt status layout: start events, then prohibited-mode writes.
  localparam int IRQ_W = 4;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
  localparam int IRQ_BAD_BASE = 2;
  // Bus encodings.
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  // Decoded configuration of one channel.
  typedef struct packed {
    logic op_clock_select;
    logic transfer_clock_source;
    logic start_trigger_select;
    logic rx_level_invert;
    logic [1:0] protocol_mode;
    logic irq_source_select;
  } chan_cfg_t;
endpackage

// ### serial_mode_cfg.sv
// Mode configuration, start control and clock selection of a two-channel serial unit.
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
module serial_mode_cfg #(
  parameter int DIV_W = 7
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Prescaler ticks and division ratios from the data registers.
  input wire logic prescaled_clock_a,
  input wire logic prescaled_clock_b,
  input wire logic [2*DIV_W-1:0] div_ratio,
  // Pins.
  input wire logic [1:0] serial_clock_pin,
  input wire logic uart_receive_pin,
  // Engine events.
  input wire logic [1:0] transfer_end_evt,
  input wire logic [1:0] buffer_empty_evt,
  // Channel outputs.
  output serial_mode_pkg::chan_cfg_t [1:0] chan_cfg,
  output logic [1:0] op_clock_tick,
  output logic [1:0] transfer_tick,
  output logic [1:0] transfer_start,
  output logic [1:0] channel_enabled_flag,
  output logic rx_data,
  output logic [1:0] channel_irq,
  output logic irq
);
  import serial_mode_pkg::*;

  // Refuse divider widths that the ratio field cannot serve.
  if (DIV_W < 1 || DIV_W > 16) begin : g_bad_div
    $error("DIV_W out of range");
  end

  // Address match against a register index.
  function automatic logic hit(input logic [31:0] a, input logic [19:0] idx);
    hit = (a == {10'h000, idx, 2'h0});
  endfunction

  logic [1:0][15:0] mode_reg; // Mode registers.
  logic [1:0] pend; // Start written, trigger not yet seen.
  logic [IRQ_W-1:0] irq_stat; // Sticky event bits.
  logic [IRQ_W-1:0] irq_mask; // Interrupt enables.
  logic rd_q; // Read data phase in progress.
  logic wr_q; // Write data phase in progress.
  logic rd_done; // Read data loaded.
  logic sz_q; // Access wide enough for the mode register.
  logic [31:0] addr_q; // Latched address.
  logic [2:0] sync1; // First synchroniser stage.
  logic [2:0] sync2; // Second synchroniser stage.
  logic [1:0] sck_last; // Previous synchronised serial clock.
  logic rx_last; // Receive level at the previous op tick.
  logic [1:0][DIV_W-1:0] div_cnt; // Divider counters.

  // Address phase is taken when selected, active and ready.
  wire take = hsel && hready && htrans[1];
  wire wr_ch0 = wr_q && hit(addr_q, CH0_MODE_IDX);
  wire wr_ch1 = wr_q && hit(addr_q, CH1_MODE_IDX);
  wire wr_start = wr_q && hit(addr_q, START_IDX);
  wire wr_istat = wr_q && hit(addr_q, IRQ_STAT_IDX);
  wire wr_imask = wr_q && hit(addr_q, IRQ_MASK_IDX);
  wire [1:0] wr_mode = {wr_ch1, wr_ch0} & {2{sz_q}};
  wire [1:0][15:0] mode_mask = {MODE_CH1_MASK, MODE_CH0_MASK};
  wire rx_s = sync2[2];
  wire [1:0] sck_s = sync2[1:0];
  wire [1:0] sck_rise = sck_s & ~sck_last;
  wire rx_uart = chan_cfg[1].protocol_mode == PROTO_UART;
  wire rx_inv = chan_cfg[1].rx_level_invert;
  wire rx_edge = op_clock_tick[1] && (rx_inv ? (rx_s && !rx_last) : (!rx_s && rx_last));
  wire [1:0] bad_wr;
  wire [1:0] start_evt;
  wire [IRQ_W-1:0] irq_evt = {bad_wr, start_evt};
  wire [IRQ_W-1:0] irq_clr = wr_istat ? hwdata[IRQ_W-1:0] : IRQ_RESET;
  wire [IRQ_W-1:0] next_irq_stat = (irq_stat & ~irq_clr) | irq_evt;
  wire [31:0] rd_mux =
    hit(addr_q, CH0_MODE_IDX) ? {16'h0000, mode_reg[0]} :
    hit(addr_q, CH1_MODE_IDX) ? {16'h0000, mode_reg[1]} :
    hit(addr_q, START_IDX) ? {30'h00000000, channel_enabled_flag} :
    hit(addr_q, IRQ_STAT_IDX) ? {28'h0000000, irq_stat} :
    hit(addr_q, IRQ_MASK_IDX) ? {28'h0000000, irq_mask} : 32'h00000000;

  // Reads take one wait state so that the returned word comes from a flop.
  assign hreadyout = !(rd_q && !rd_done);
  assign hresp = 1'b0;
  assign irq = |(irq_stat & irq_mask);

  // Bus phase tracking and read data register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      rd_done <= 1'b0;
      sz_q <= 1'b0;
      addr_q <= 32'h00000000;
      hrdata <= 32'h00000000;
    end else if (hreadyout) begin
      rd_q <= take && !hwrite;
      wr_q <= take && hwrite;
      sz_q <= hsize != HSIZE_BYTE;
      addr_q <= haddr;
      rd_done <= 1'b0;
    end else begin
      hrdata <= rd_mux;
      rd_done <= 1'b1;
    end
  end

  // Pin synchronisers and edge memory.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // The receive line idles high, so its stages start high to avoid a false edge.
      sync1 <= 3'h4;
      sync2 <= 3'h4;
      sck_last <= 2'h0;
      rx_last <= 1'b1;
      rx_data <= 1'b0;
    end else begin
      sync1 <= {uart_receive_pin, serial_clock_pin};
      sync2 <= sync1;
      sck_last <= sck_s;
      // The edge detector samples on the op clock.
      if (op_clock_tick[1]) begin
        rx_last <= rx_s;
      end
      // Data inverted in UART mode when selected.
      rx_data <= rx_s ^ (rx_inv && rx_uart);
    end
  end

  // Interrupt status and mask.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat <= IRQ_RESET;
      irq_mask <= IRQ_RESET;
    end else begin
      irq_stat <= next_irq_stat;
      if (wr_imask) begin
        irq_mask <= hwdata[IRQ_W-1:0];
      end
    end
  end

  // Per-channel configuration, clocking and start control.
  for (genvar n = 0; n < 2; n++) begin : g_ch
    wire [15:0] wval = (hwdata[15:0] & mode_mask[n]) | MODE_FIXED_ONE;
    // While enabled only the irq source bit moves.
    wire [15:0] next_mode = channel_enabled_flag[n] ?
      {mode_reg[n][15:1], wval[MD_IRQ_BIT]} : wval;
    wire [DIV_W-1:0] ratio = div_ratio[n*DIV_W +: DIV_W];
    wire div_hit = op_clock_tick[n] && (div_cnt[n] == ratio);
    // Channel 1 may wait for a receive edge.
    wire trig = (n == 1 && chan_cfg[n].start_trigger_select) ? rx_edge : 1'b1;
    wire go = pend[n] && trig;
    assign start_evt[n] = go;
    // Prohibited protocol code raises an event.
    assign bad_wr[n] = wr_mode[n] && (hwdata[MD_HI_BIT:MD_LO_BIT] == PROTO_BAD);
    // Masked positions force zero on channel 0.
    assign chan_cfg[n].op_clock_select = mode_reg[n][CKS_BIT];
    assign chan_cfg[n].transfer_clock_source = mode_reg[n][CCS_BIT];
    assign chan_cfg[n].start_trigger_select = mode_reg[n][STS_BIT];
    assign chan_cfg[n].rx_level_invert = mode_reg[n][SIS_BIT];
    assign chan_cfg[n].protocol_mode = mode_reg[n][MD_HI_BIT:MD_LO_BIT];
    assign chan_cfg[n].irq_source_select = mode_reg[n][MD_IRQ_BIT];
    assign op_clock_tick[n] = chan_cfg[n].op_clock_select ? prescaled_clock_b : prescaled_clock_a;
    // Transfer tick runs only while the channel operates.
    assign transfer_tick[n] = channel_enabled_flag[n] &&
      (chan_cfg[n].transfer_clock_source ? sck_rise[n] : div_hit);
    assign transfer_start[n] = go;

    // Mode register, divider, start pending and enable.
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        mode_reg[n] <= MODE_RESET;
        div_cnt[n] <= '0;
        pend[n] <= 1'b0;
        channel_enabled_flag[n] <= 1'b0;
        channel_irq[n] <= 1'b0;
      end else begin
        if (wr_mode[n]) begin
          mode_reg[n] <= next_mode;
        end
        // Divide the op clock by ratio plus one.
        if (!channel_enabled_flag[n] || div_hit) begin
          div_cnt[n] <= '0;
        end else if (op_clock_tick[n]) begin
          div_cnt[n] <= div_cnt[n] + 1'b1;
        end
        // Start waits for the trigger; stop wins.
        if (wr_start && hwdata[STOP_BASE+n]) begin
          pend[n] <= 1'b0;
          channel_enabled_flag[n] <= 1'b0;
        end else if (wr_start && hwdata[n]) begin
          pend[n] <= 1'b1;
        end else if (go) begin
          pend[n] <= 1'b0;
          channel_enabled_flag[n] <= 1'b1;
        end
        channel_irq[n] <= chan_cfg[n].irq_source_select ? buffer_empty_evt[n] : transfer_end_evt[n];
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_FIXED_ONE: assert property (mode_reg[0][5] && mode_reg[1][5])
    else $error("fixed-one bit lost");
  AST_BYTE_DROP: assert property (wr_q && !sz_q |=> $stable(mode_reg))
    else $error("byte write changed mode");
  AST_OP_CLK: assert property (op_clock_tick[1] == (mode_reg[1][CKS_BIT] ? prescaled_clock_b : prescaled_clock_a))
    else $error("wrong op clock");
  AST_DIV_SRC: assert property (transfer_tick[0] && !mode_reg[0][CCS_BIT] |-> op_clock_tick[0])
    else $error("divided tick without op tick");
  AST_EXT_SRC: assert property (transfer_tick[1] && mode_reg[1][CCS_BIT] |-> sck_rise[1])
    else $error("pin tick without pin edge");
  AST_TICK_EN: assert property (transfer_tick != 2'h0 |-> (transfer_tick & ~channel_enabled_flag) == 2'h0)
    else $error("tick on idle channel");
  AST_RX_TRIG: assert property (transfer_start[1] && mode_reg[1][STS_BIT] |-> rx_edge)
    else $error("rx start without edge");
  AST_START: assert property ($rose(channel_enabled_flag[0]) |-> $past(pend[0]))
    else $error("enable without start");
  AST_INVERT: assert property (1'b1 |=> rx_data == ($past(rx_s) ^ $past(rx_inv && rx_uart)))
    else $error("receive inversion wrong");
  AST_BAD_MODE: assert property (wr_ch0 && sz_q && hwdata[2:1] == PROTO_BAD |=> irq_stat[IRQ_BAD_BASE])
    else $error("prohibited mode not flagged");
  AST_IRQ_SRC: assert property (mode_reg[0][MD_IRQ_BIT] && buffer_empty_evt[0] |=> channel_irq[0])
    else $error("buffer empty irq lost");
  AST_CH0_ZERO: assert property (!mode_reg[0][STS_BIT] && !mode_reg[0][SIS_BIT])
    else $error("channel 0 fixed zero bits set");
  AST_LOCK: assert property (channel_enabled_flag[1] && wr_ch1 |=> mode_reg[1][15:1] == $past(mode_reg[1][15:1]))
    else $error("mode changed while enabled");

  COV_SW_START: cover property (pend[0] ##1 channel_enabled_flag[0]);
  COV_RX_START: cover property (transfer_start[1] && mode_reg[1][STS_BIT]);
  COV_EXT_TICK: cover property (transfer_tick[0] && mode_reg[0][CCS_BIT]);
  COV_IRQ: cover property (irq);
endmodule

// ### serial_mode_cfg_test.sv
// Self-checking testbench of the serial channel mode configuration block.
`timescale 1ns/1ps
module serial_mode_cfg_test;
  import serial_mode_pkg::*;
  // Bus master signals, all idle at time zero.
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 0;
  // Prescaler ticks, pins and engine events.
  logic pa = 0, pb = 0, rx = 1, hreadyout, hresp, irq, rx_data;
  logic [13:0] div_ratio = 0;
  logic [1:0] sck = 0, te = 0, be = 0, op_clock_tick, transfer_tick, transfer_start, channel_enabled_flag, channel_irq;
  chan_cfg_t [1:0] chan_cfg;
  // Counters of the run.
  int fails = 0, n_compared = 0, cycles = 0, cnt, tk1;
  // Byte addresses: four times the register index.
  localparam logic [31:0] A0 = {10'h0, CH0_MODE_IDX, 2'h0};
  localparam logic [31:0] A1 = {10'h0, CH1_MODE_IDX, 2'h0};
  localparam logic [31:0] AS = {10'h0, START_IDX, 2'h0};
  localparam logic [31:0] AI = {10'h0, IRQ_STAT_IDX, 2'h0};
  localparam logic [31:0] AM = {10'h0, IRQ_MASK_IDX, 2'h0};

  serial_mode_cfg #(.DIV_W(7)) serial_mode_cfg_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .prescaled_clock_a(pa), .prescaled_clock_b(pb), .div_ratio(div_ratio),
    .serial_clock_pin(sck), .uart_receive_pin(rx), .transfer_end_evt(te), .buffer_empty_evt(be),
    .chan_cfg(chan_cfg), .op_clock_tick(op_clock_tick), .transfer_tick(transfer_tick),
    .transfer_start(transfer_start), .channel_enabled_flag(channel_enabled_flag), .rx_data(rx_data),
    .channel_irq(channel_irq), .irq(irq));

  // Clock of 8 ns period.
  initial begin
    forever #4 hclk = ~hclk;
  end

  // Hang guard and channel 1 transfer tick counter.
  always @(posedge hclk) begin
    cycles++;
    if (cycles > 20000) begin
      fails++;
      test_done();
    end
  end
  always @(negedge hclk) begin
    tk1 += transfer_tick[1];
  end

  // Compares one value and reports a mismatch.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits for hready high at a rising edge, taking read data there.
  task bus_wait();
    logic ok;
    int n;
    n = 0;
    do begin
      @(negedge hclk);
      ok = hreadyout;
      rd = hrdata;
      @(posedge hclk);
      n++;
    end while (ok !== 1'b1 && n < 20);
    if (ok !== 1'b1) begin
      fails++;
      $display("[ERR] %0t bus wait limit reached", $time);
    end
  endtask

  // One single transfer: address phase, then data phase.
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [2:0] sz);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= sz;
    bus_wait();
    htrans <= 2'h0;
    hwdata <= d;
    bus_wait();
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 3'h2);
  endtask
  task rdchk(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, 3'h2);
    chk(rd, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask

  // Reset values, writable bits, prohibited mode, byte and unmapped access.
  task t_regs();
    rdchk(A0, 32'h0020);
    rdchk(A1, 32'h0020);
    wr(A0, 32'hFFFF);
    rdchk(A0, 32'hC027);
    wr(A1, 32'hFFFF);
    rdchk(A1, 32'hC167);
    chk({25'h0, chan_cfg[1]}, 32'h7F);
    rdchk(AI, 32'hC);
    wr(AI, 32'hF);
    rdchk(AI, 32'h0);
    xfer(1'b1, A0, 32'h0, HSIZE_BYTE);
    rdchk(A0, 32'hC027);
    wr(AM + 32'h8, 32'hFFFF);
    rdchk(AM + 32'h8, 32'h0);
  endtask

  // Operation clock follows the select bit.
  task t_clock();
    wr(A0, 32'h8020);
    @(posedge hclk);
    pb <= 1'b1;
    @(negedge hclk);
    chk(op_clock_tick[0], 1'b1);
    wr(A0, 32'h0020);
    @(negedge hclk);
    chk(op_clock_tick[0], 1'b0);
  endtask

  // Software start, interrupt, divided clock, locked fields, stop.
  task t_start();
    wr(AM, 32'h1);
    @(posedge hclk);
    pa <= 1'b1;
    pb <= 1'b0;
    div_ratio <= 14'h2;
    wr(AS, 32'h1);
    @(negedge hclk);
    chk(transfer_start[0], 1'b1);
    @(negedge hclk);
    chk(channel_enabled_flag[0], 1'b1);
    chk(irq, 1'b1);
    cnt = 0;
    repeat (30) begin
      @(negedge hclk);
      cnt += transfer_tick[0];
    end
    chk(cnt, 10);
    wr(A0, 32'h8021);
    rdchk(A0, 32'h0021);
    wr(AI, 32'h1);
    @(negedge hclk);
    chk(irq, 1'b0);
    wr(AS, 32'h100);
    @(negedge hclk);
    chk(channel_enabled_flag[0], 1'b0);
  endtask

  // Channel 1 waits for a receive edge; its interrupt stays masked.
  task t_trigger();
    wr(A1, 32'h0122);
    wr(AS, 32'h2);
    repeat (8) @(posedge hclk);
    chk(channel_enabled_flag[1], 1'b0);
    rx <= 1'b0;
    cnt = 0;
    repeat (8) begin
      @(negedge hclk);
      cnt += transfer_start[1];
    end
    chk(cnt, 1);
    chk(channel_enabled_flag[1], 1'b1);
    chk(irq, 1'b0);
    rdchk(AI, 32'h2);
    wr(AS, 32'h200);
  endtask

  // Receive data inversion in UART mode.
  task t_invert();
    wr(A1, 32'h0062);
    repeat (4) @(negedge hclk);
    chk(rx_data, 1'b1);
    @(posedge hclk);
    rx <= 1'b1;
    repeat (4) @(negedge hclk);
    chk(rx_data, 1'b0);
    wr(A1, 32'h0022);
    repeat (2) @(negedge hclk);
    chk(rx_data, 1'b1);
  endtask

  // Interrupt source select: each event kind against each setting.
  task t_irqsrc();
    for (int k = 0; k < 4; k++) begin
      wr(A0, 32'h20 | k[1]);
      @(posedge hclk);
      te <= {1'b0, ~k[0]};
      be <= {1'b0, k[0]};
      @(posedge hclk);
      te <= 2'h0;
      be <= 2'h0;
      @(negedge hclk);
      chk(channel_irq[0], k[1] == k[0]);
    end
  endtask

  // Transfer ticks from the serial clock pin in slave operation.
  task t_pinclk();
    wr(A1, 32'h4020);
    wr(AS, 32'h2);
    tk1 = 0;
    repeat (3) begin
      @(posedge hclk);
      sck <= 2'h2;
      repeat (4) @(posedge hclk);
      sck <= 2'h0;
      repeat (4) @(posedge hclk);
    end
    chk(tk1, 3);
    wr(AS, 32'h200);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task test_done();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence after four cycles of reset.
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_clock();
    t_start();
    t_trigger();
    t_invert();
    t_irqsrc();
    t_pinclk();
    test_done();
  end
endmodule
